// ===== verilog/aps_defs.svh
// register map, field positions, reset values and codes of the protection register bank
`ifndef APS_DEFS_SVH
`define APS_DEFS_SVH
`define APS_ADDR_BATT 8'h06
`define APS_ADDR_LIM1 8'h07
`define APS_ADDR_KNEE 8'h09
`define APS_ADDR_FLAGS 8'h0A
`define APS_ADDR_FAULT 8'h0B
`define APS_RST_LIM1 8'hA4
`define APS_RST_KNEE 8'h22
`define APS_RST_FLAGS 8'h00
`define APS_RST_FAULT 8'h18
`define APS_RST_BATT 8'h00
`define APS_READ_ZERO 8'h00
// fault control fields
`define APS_ATTEN_HI 7
`define APS_ATTEN_LO 6
`define APS_MANUAL_BIT 5
`define APS_RCV_HI 4
`define APS_RCV_LO 3
`define APS_SEL_UV 2
`define APS_SEL_OT 1
`define APS_SEL_OC 0
// limiter control 1 mode field
`define APS_MODE_HI 1
`define APS_MODE_LO 0
`define APS_MODE_OFF 2'h0
`define APS_MODE_ON 2'h1
`define APS_MODE_MUTE 2'h2
`define APS_MODE_LOWBAT 2'h3
// status bit positions
`define APS_ST_RSVD 7
`define APS_ST_UV 6
`define APS_ST_GAIN 5
`define APS_ST_CLIP 4
`define APS_ST_OC 3
`define APS_ST_OT_FAULT 2
`define APS_ST_OT_WARN 1
`define APS_ST_BAT 0
// recovery attempt limits by field code
`define APS_RCV_ONE 2'h0
`define APS_RCV_THREE 2'h1
`define APS_RCV_SEVEN 2'h2
`define APS_RCV_UNLIM 2'h3
`define APS_LIM_ONE 3'h1
`define APS_LIM_THREE 3'h3
`define APS_LIM_SEVEN 3'h7
`define APS_CNT_ZERO 3'h0
`define APS_CNT_ONE 3'h1
// attenuation codes: 0 none, 1 1.5 dB, 2 3 dB, 3 5.625 dB
`define APS_ATTEN_NONE 2'h0
`endif

// ===== verilog/aps_pkg.sv
// types shared by the protection register bank
package aps_pkg;
  typedef struct packed {
    logic uv;
    logic gain_red;
    logic clip;
    logic oc;
    logic ot_fault;
    logic ot_warn;
  } aps_cond_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aps_req_t;
endpackage

// ===== verilog/aps_regs.sv
// protection and status register bank with fault recovery control
// How it works
// RQ1 - An eight-bit knee threshold resetting to 0x22 is compared with the battery reading.
// RQ2 - Software turns a threshold code into volts as 3.8 plus 12.4 times code over 255.
// RQ3 - Status bits 6, 3, 2 and 1 follow undervoltage, overcurrent, overtemp fault and warning.
// RQ4 - Status bit 5 follows gain reduction and bit 4 follows clipping.
// RQ5 - Status bit 0 is set when the battery reading is at or below the threshold.
// RQ6 - During a thermal warning the two-bit attenuation code is applied, else none.
// RQ7 - Writing 1 to the manual trigger starts one recovery only when the setting field is 11.
// RQ8 - Automatic attempts are limited to 1, 3, 7 or unlimited, resetting to unlimited.
// RQ9 - Undervoltage recovers automatically when its select is 0, manually when 1.
// RQ10 - Overtemperature recovers automatically when its select is 0, manually when 1.
// RQ11 - Overcurrent recovers automatically when its select is 0, manually when 1.
// RQ12 - Mode 10 mutes while the battery is low and mode 11 engages the limiter only then.
// RQ13 - The synchronised battery reading is readable and is what the threshold is compared with.
// RQ14 - Status writes are ignored and the flags follow live conditions every cycle.
`include "aps_defs.svh"
module aps_regs
  import aps_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  input wire aps_req_t REQ_I,
  output logic [7:0] RDATA_O,
  output logic RVALID_O,
  input wire aps_cond_t COND_I,
  input wire logic [7:0] BATT_I,
  output logic MUTE_O,
  output logic LIMITER_ON_O,
  output logic [1:0] ATTEN_O,
  output logic [2:0] SHUTDOWN_O,
  output logic [2:0] RECOVER_O,
  output logic EXHAUSTED_O
);
  // ==========================================
  // input synchronisers
  aps_cond_t c_q1, c_q2, c_q3, cond;
  logic [7:0] b_q1, b_q2, b_q3, batt;
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      c_q1 <= '0;
      c_q2 <= '0;
      c_q3 <= '0;
      b_q1 <= `APS_RST_BATT;
      b_q2 <= `APS_RST_BATT;
      b_q3 <= `APS_RST_BATT;
    end
    else if (CE_I)
    begin
      c_q1 <= COND_I;
      c_q2 <= c_q1;
      c_q3 <= c_q2;
      b_q1 <= BATT_I;
      b_q2 <= b_q1;
      b_q3 <= b_q2;
    end
  end
  // per-bit agreement for flags; whole word for the reading so no torn value lands
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      cond <= '0;
      batt <= `APS_RST_BATT;
    end
    else if (CE_I)
    begin
      cond <= (c_q2 & c_q3) | (cond & (c_q2 | c_q3));
      if (b_q2 == b_q3)
        batt <= b_q2; // see RQ13
    end
  end

  // ==========================================
  // registers
  logic [7:0] lim1, knee, fault;
  logic manual_go;
  logic wr_fault;
  assign wr_fault = CE_I && REQ_I.wr && REQ_I.addr == `APS_ADDR_FAULT;
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      lim1 <= `APS_RST_LIM1;
      knee <= `APS_RST_KNEE; // see RQ1
      fault <= `APS_RST_FAULT; // see RQ8
    end
    else if (CE_I && REQ_I.wr)
    begin
      // status and battery offsets fall through: writes there are dropped
      case (REQ_I.addr)
        `APS_ADDR_LIM1: lim1 <= REQ_I.wdata;
        `APS_ADDR_KNEE: knee <= REQ_I.wdata;
        `APS_ADDR_FAULT:
        begin
          fault <= REQ_I.wdata;
          fault[`APS_MANUAL_BIT] <= 1'b0; // write-only trigger never stored
        end
        default: ;
      endcase
    end
  end

  // single-cycle trigger; a 0 write or a setting other than 11 does nothing
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      manual_go <= 1'b0;
    else if (CE_I)
      manual_go <= wr_fault && REQ_I.wdata[`APS_MANUAL_BIT]
        && fault[`APS_RCV_HI:`APS_RCV_LO] == `APS_RCV_UNLIM; // see RQ7
  end

  // ==========================================
  // status and monitor outputs
  logic low_bat;
  logic [7:0] flags;
  logic [1:0] mode;
  assign low_bat = batt <= knee; // see RQ5
  assign mode = lim1[`APS_MODE_HI:`APS_MODE_LO];
  always_comb
  begin
    flags = `APS_RST_FLAGS;
    flags[`APS_ST_UV] = cond.uv; // see RQ3
    flags[`APS_ST_OC] = cond.oc; // see RQ3
    flags[`APS_ST_OT_FAULT] = cond.ot_fault; // see RQ3
    flags[`APS_ST_OT_WARN] = cond.ot_warn; // see RQ3
    flags[`APS_ST_GAIN] = cond.gain_red; // see RQ4
    flags[`APS_ST_CLIP] = cond.clip; // see RQ4
    flags[`APS_ST_BAT] = low_bat; // see RQ5
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      MUTE_O <= 1'b0;
      LIMITER_ON_O <= 1'b0;
      ATTEN_O <= `APS_ATTEN_NONE;
    end
    else if (CE_I)
    begin
      MUTE_O <= mode == `APS_MODE_MUTE && low_bat; // see RQ12
      LIMITER_ON_O <= mode == `APS_MODE_ON || (mode == `APS_MODE_LOWBAT && low_bat); // see RQ12
      ATTEN_O <= cond.ot_warn ? fault[`APS_ATTEN_HI:`APS_ATTEN_LO] : `APS_ATTEN_NONE; // see RQ6
    end
  end

  // ==========================================
  // register read port, one cycle latency
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      RDATA_O <= `APS_READ_ZERO;
      RVALID_O <= 1'b0;
    end
    else if (CE_I)
    begin
      RVALID_O <= REQ_I.rd;
      if (REQ_I.rd)
      begin
        case (REQ_I.addr)
          `APS_ADDR_BATT: RDATA_O <= batt; // see RQ13
          `APS_ADDR_LIM1: RDATA_O <= lim1;
          `APS_ADDR_KNEE: RDATA_O <= knee;
          `APS_ADDR_FLAGS: RDATA_O <= flags; // see RQ14
          `APS_ADDR_FAULT: RDATA_O <= fault;
          default: RDATA_O <= `APS_READ_ZERO;
        endcase
      end
    end
  end

  // ==========================================
  // fault hold and recovery; index 0 overcurrent, 1 overtemp, 2 undervoltage
  logic [2:0] live, sel, held_prev, auto_go, man_go;
  logic [2:0] attempts, limit;
  logic unlimited;
  assign live = {cond.uv, cond.ot_fault, cond.oc};
  assign sel = {fault[`APS_SEL_UV], fault[`APS_SEL_OT], fault[`APS_SEL_OC]};
  assign unlimited = fault[`APS_RCV_HI:`APS_RCV_LO] == `APS_RCV_UNLIM;
  always_comb
  begin
    case (fault[`APS_RCV_HI:`APS_RCV_LO])
      `APS_RCV_ONE: limit = `APS_LIM_ONE;
      `APS_RCV_THREE: limit = `APS_LIM_THREE;
      `APS_RCV_SEVEN: limit = `APS_LIM_SEVEN;
      default: limit = `APS_LIM_SEVEN;
    endcase
  end
  assign EXHAUSTED_O = !unlimited && attempts >= limit; // see RQ8
  // recovery waits for the condition to clear, so a stuck fault never retries
  assign auto_go = SHUTDOWN_O & ~live & ~sel & {3{!EXHAUSTED_O}}; // see RQ9
  assign man_go = SHUTDOWN_O & ~live & sel & {3{manual_go}}; // see RQ10
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      SHUTDOWN_O <= '0;
      held_prev <= '0;
      RECOVER_O <= '0;
    end
    else if (CE_I)
    begin
      held_prev <= live;
      RECOVER_O <= auto_go | man_go; // see RQ11
      // a new fault edge wins over a recovery in the same cycle
      SHUTDOWN_O <= (SHUTDOWN_O & ~(auto_go | man_go)) | (live & ~held_prev);
    end
  end
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
      attempts <= `APS_CNT_ZERO;
    else if (CE_I)
    begin
      if (manual_go)
        attempts <= `APS_CNT_ZERO;
      else if (|auto_go && !unlimited)
        attempts <= attempts + `APS_CNT_ONE; // see RQ8
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  AST_KNEE_WRITE: assert property (CE_I && REQ_I.wr // see RQ1
    && REQ_I.addr == `APS_ADDR_KNEE
    |=> knee == $past(REQ_I.wdata)) else $error("knee threshold not stored");
  // checked on the read port so a wrong bit position in the status word shows up
  AST_FLAGS_LIVE: assert property (CE_I && REQ_I.rd // see RQ3
    && REQ_I.addr == `APS_ADDR_FLAGS
    |=> RDATA_O[`APS_ST_OT_FAULT] == $past(cond.ot_fault)
    && RDATA_O[`APS_ST_UV] == $past(cond.uv)
    && RDATA_O[`APS_ST_OC] == $past(cond.oc)
    && RDATA_O[`APS_ST_RSVD] == 1'b0)
    else $error("status word does not follow conditions");
  AST_LOWBAT: assert property (CE_I && batt <= knee // see RQ12
    && mode == `APS_MODE_MUTE
    ##1 CE_I |-> MUTE_O) else $error("mute missing on low battery");
  AST_BAT_FLAG: assert property (CE_I && REQ_I.rd // see RQ5
    && REQ_I.addr == `APS_ADDR_FLAGS
    |=> RDATA_O[`APS_ST_BAT] == ($past(batt) <= $past(knee)))
    else $error("battery flag wrong");
  AST_ATTEN: assert property (CE_I && !cond.ot_warn // see RQ6
    |=> ATTEN_O == `APS_ATTEN_NONE)
    else $error("attenuation without warning");
  AST_MANUAL: assert property (CE_I && REQ_I.wr // see RQ7
    && REQ_I.addr == `APS_ADDR_FAULT
    && fault[`APS_RCV_HI:`APS_RCV_LO] != `APS_RCV_UNLIM |=> !manual_go)
    else $error("manual trigger outside setting 11");
  AST_EXHAUST: assert property (CE_I && EXHAUSTED_O && !manual_go // see RQ8
    |=> RECOVER_O == 3'h0)
    else $error("auto recovery past the limit");
  AST_SEL_AUTO: assert property (CE_I && SHUTDOWN_O[0] // see RQ11
    && !live[0] && !sel[0] && !EXHAUSTED_O
    |=> RECOVER_O[0]) else $error("auto overcurrent recovery missed");
  AST_SEL_MAN: assert property (CE_I && sel[1] && !manual_go // see RQ10
    |=> !RECOVER_O[1])
    else $error("overtemp recovered without request");
  AST_STATUS_RO: assert property (CE_I && REQ_I.wr // see RQ14
    && REQ_I.addr == `APS_ADDR_FLAGS
    |=> $stable(knee) && $stable(fault)) else $error("status write had effect");
  COV_MUTE: cover property (MUTE_O);
  COV_AUTO: cover property (|RECOVER_O ##[1:20] |RECOVER_O);
  COV_MANUAL: cover property (manual_go ##1 |RECOVER_O);
  COV_EXHAUST: cover property (EXHAUSTED_O);
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the protection register bank
`include "aps_defs.svh"
module tb_top
  import aps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  aps_req_t req = '0;
  aps_cond_t cond = '0;
  logic [7:0] batt = 8'hFF;
  logic [7:0] rdata;
  logic rvalid, mute, lim_on, exhausted;
  logic [1:0] atten;
  logic [2:0] shutdown, recover;
  int miscompares = 0;
  int num_checks = 0;
  int cbit[3] = '{2, 1, 5};
  always #4 clk = ~clk;
  aps_regs dut (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .REQ_I(req), .RDATA_O(rdata),
    .RVALID_O(rvalid), .COND_I(cond), .BATT_I(batt), .MUTE_O(mute), .LIMITER_ON_O(lim_on),
    .ATTEN_O(atten), .SHUTDOWN_O(shutdown), .RECOVER_O(recover), .EXHAUSTED_O(exhausted));
  // ==========================================
  // bus tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // trailing idle cycle keeps two strobes from landing in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    step(1);
    req.wr = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.rd = 1'b1;
    req.addr = a;
    step(1);
    req.rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk("rdata", exp, rdata);
    step(1);
  endtask
  task automatic wait_rec(input int b, input logic exp);
    logic hit;
    hit = 1'b0;
    // look before stepping: a manual pulse already stands when the write task returns
    repeat (20)
    begin
      if (recover[b] === 1'b1)
      begin
        hit = 1'b1;
        chk("shutdown at recovery", 8'h00, {7'h00, shutdown[b]});
      end
      step(1);
    end
    chk("recovery pulse", {7'h00, exp}, {7'h00, hit});
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================
  // tests
  initial
  begin
    step(5);
    rst = 1'b0;
    rd(`APS_ADDR_KNEE, 8'h22);
    rd(`APS_ADDR_FAULT, 8'h18);
    rd(8'h0C, 8'h00);
    wr(`APS_ADDR_FLAGS, 8'hFF);
    wr(`APS_ADDR_BATT, 8'h11);
    // code 80 stands for about 10.0 V on the battery scale
    wr(`APS_ADDR_KNEE, 8'h80);
    rd(`APS_ADDR_FLAGS, 8'h00);
    rd(`APS_ADDR_BATT, 8'hFF);
    rd(`APS_ADDR_KNEE, 8'h80);
    // a write while the clock enable is low must be dropped
    ce = 1'b0;
    wr(`APS_ADDR_KNEE, 8'h33);
    ce = 1'b1;
    rd(`APS_ADDR_KNEE, 8'h80);
    $display("test registers done");
    batt = 8'h80;
    step(8);
    rd(`APS_ADDR_BATT, 8'h80);
    rd(`APS_ADDR_FLAGS, 8'h01);
    wr(`APS_ADDR_LIM1, 8'hA6);
    step(6);
    chk("mute", 8'h01, {7'h00, mute});
    wr(`APS_ADDR_LIM1, 8'hA7);
    step(6);
    chk("limiter", 8'h01, {7'h00, lim_on});
    chk("mute off", 8'h00, {7'h00, mute});
    batt = 8'h81;
    step(8);
    rd(`APS_ADDR_FLAGS, 8'h00);
    chk("limiter idle", 8'h00, {7'h00, lim_on});
    wr(`APS_ADDR_LIM1, 8'hA5);
    step(6);
    chk("limiter always", 8'h01, {7'h00, lim_on});
    chk("mute in limiter mode", 8'h00, {7'h00, mute});
    wr(`APS_ADDR_LIM1, 8'hA4);
    $display("test battery done");
    for (int k = 0; k < 6; k++)
    begin
      cond = aps_cond_t'(6'h01 << k);
      step(8);
      rd(`APS_ADDR_FLAGS, 8'h01 << (k + 1));
      cond = '0;
      step(20);
    end
    $display("test status done");
    for (int c = 0; c < 4; c++)
    begin
      wr(`APS_ADDR_FAULT, {c[1:0], 6'h18});
      cond.ot_warn = 1'b1;
      step(8);
      chk("atten", {6'h00, c[1:0]}, {6'h00, atten});
      cond.ot_warn = 1'b0;
      step(8);
      chk("atten idle", 8'h00, {6'h00, atten});
    end
    wr(`APS_ADDR_FAULT, 8'h18);
    $display("test attenuation done");
    for (int i = 0; i < 3; i++)
    begin
      cond = aps_cond_t'(6'h01 << cbit[i]);
      step(8);
      chk("shutdown", 8'h01, {7'h00, shutdown[i]});
      cond = '0;
      wait_rec(i, 1'b1);
    end
    $display("test auto recovery done");
    wr(`APS_ADDR_FAULT, 8'h00);
    cond.oc = 1'b1;
    step(8);
    cond.oc = 1'b0;
    wait_rec(0, 1'b1);
    chk("exhausted", 8'h01, {7'h00, exhausted});
    cond.oc = 1'b1;
    step(8);
    cond.oc = 1'b0;
    wait_rec(0, 1'b0);
    chk("held fault", 8'h01, {7'h00, shutdown[0]});
    // trigger while the setting is not 11 must do nothing
    wr(`APS_ADDR_FAULT, 8'h21);
    wait_rec(0, 1'b0);
    wr(`APS_ADDR_FAULT, 8'h19);
    wr(`APS_ADDR_FAULT, 8'h39);
    wait_rec(0, 1'b1);
    rd(`APS_ADDR_FAULT, 8'h19);
    $display("test manual recovery done");
    print_verdict();
  end
  initial
  begin
    #100us;
    miscompares++;
    print_verdict();
  end
endmodule
